/* File: rtl/current_monitor_consts.vh */
// Constants for the current monitor configuration register bank.
// Included by the register bank and its glitch filter module.
`ifndef CURRENT_MONITOR_CONSTS_VH
`define CURRENT_MONITOR_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LOW_CFG_A_ADDR 8'h34
`define LOW_CFG_B_ADDR 8'h35
`define HIGH_CFG_A_ADDR 8'h36
`define HIGH_CFG_B_ADDR 8'h37

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_A_RESET 8'h00
`define CFG_B_RESET 8'h00
`define RD_IDLE 8'h00

// ----------------------------------------
// First configuration byte fields
// ----------------------------------------
`define FAST_MSB 7
`define FAST_LSB 5
`define BYPASS_BIT 4
`define WINDOW_BIT 3
`define LOWSIDE_BIT 2
// Writable bits: low channel keeps 7:2, high channel keeps 7:3
`define LOW_A_MASK 8'hFC
`define HIGH_A_MASK 8'hF8

// ----------------------------------------
// Second configuration byte fields
// ----------------------------------------
`define ATH_MSB 7
`define ATH_LSB 6
`define BTH_MSB 5
`define BTH_LSB 4
`define AGAIN_MSB 3
`define AGAIN_LSB 2
`define BGAIN_MSB 1
`define BGAIN_LSB 0

// ----------------------------------------
// Gain codes in V/V
// ----------------------------------------
`define GAIN_CODE0 7'h64
`define GAIN_CODE1 7'h32
`define GAIN_CODE2 7'h19
`define GAIN_CODE3 7'h0A

// ----------------------------------------
// Glitch filter
// ----------------------------------------
`define FILT_TIME_NS 200
`define CLK_PERIOD_NS 50
// Least time, rounded up to whole cycles
`define FILT_CYCLES ((`FILT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W 3
`define FILT_ZERO 3'h0
`define FILT_ONE 3'h1

`endif

/* File: rtl/glitch_filter.v */
// One glitch filter per comparator output, with a bypass path.
// Assumes the comparator input is already synchronous to clk.
`timescale 1ns/10ps

module glitch_filter (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Control
    input wire bypass,
    // Comparator level in, filtered level out
    input wire compIn,
    output reg compOut_ff
);

`include "current_monitor_consts.vh"

// ----------------------------------------
// Filter state
// ----------------------------------------
reg [`FILT_CNT_W-1:0] cnt_ff;
reg stable_ff;
// Sized copy of the filter length so the counter compare stays 3 bits wide
localparam [31:0] FILT_LEN = `FILT_CYCLES;
wire [`FILT_CNT_W-1:0] cntMax = FILT_LEN[`FILT_CNT_W-1:0];

// Input must hold a new level for the whole filter time
always @(posedge clk) begin
    if (sys_rst) begin
        cnt_ff <= `FILT_ZERO;
        stable_ff <= 1'b0;
    end else if (compIn == stable_ff) begin
        cnt_ff <= `FILT_ZERO;
    end else if (cnt_ff == cntMax - `FILT_ONE) begin
        cnt_ff <= `FILT_ZERO;
        stable_ff <= compIn;
    end else begin
        cnt_ff <= cnt_ff + `FILT_ONE;
    end
end

// Bypass picks the raw level; filter keeps running so a switch back is clean
always @(posedge clk) begin
    if (sys_rst) begin
        compOut_ff <= 1'b0;
    end else begin
        compOut_ff <= bypass ? compIn : stable_ff; // R8
    end
end

endmodule

/* File: rtl/current_monitor_config_regs.v */
// Configuration register bank for the two current monitor channels.
// Assumes a serial management engine decodes bus frames into byte
// writes and reads, and a config loader may push whole bytes.
// Comparator levels arrive already synchronous to clk; the analog
// section reads the decoded controls straight from these flops.
//
// Function
// R1: Host rewrites trip codes, filter and window settings over the serial bus.
// R2: Low channel byte A: fast code 7:5, bypass 4, window 3, low-side 2, zeros.
// R3: High channel byte A matches low, bit 2 ignored, no low-side option.
// R4: Byte B: A threshold 7:6, B threshold 5:4, A gain 3:2, B gain 1:0.
// R5: Trip point from threshold and gain; gains 100, 50, 25, 10 V/V.
// R6: Same decoding both channels; range 8 mV to 190 mV differential.
// R7: Every comparator output of each channel has its own glitch filter.
// R8: Bypass bit 0 keeps filters active, 1 skips them.
// R9: Window mode per channel, off at 0, on at 1.
// R10: Low-side sensing only on low channel, enabled when bit is 1.
// R11: Registers writable as master or slave and by config load operation.
// R12: Fast code steps 50 mV to 300 mV, then 400 and 500 mV.
// R13: Reads return the last written value, fixed-zero bits as zero.
`timescale 1ns/10ps

module current_monitor_config_regs (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register access from the serial management engine
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData_ff,
    output reg regRdValid_ff,
    // Configuration load operation
    input wire loadCfgEn,
    input wire [7:0] loadCfgAddr,
    input wire [7:0] loadCfgData,
    // Raw comparator outputs: bit0 fast, bit1 A, bit2 B
    input wire [2:0] lowCompRaw,
    input wire [2:0] highCompRaw,
    // Low-voltage channel controls to the analog section
    output reg [2:0] lowFastTripCode_ff,
    output reg lowWindowSel_ff,
    output reg lowLowSideEnable_ff,
    output reg [1:0] lowCompAThreshold_ff,
    output reg [1:0] lowCompBThreshold_ff,
    output reg [6:0] lowGainA_ff,
    output reg [6:0] lowGainB_ff,
    // High-voltage channel controls to the analog section
    output reg [2:0] highFastTripCode_ff,
    output reg highWindowSel_ff,
    output reg [1:0] highCompAThreshold_ff,
    output reg [1:0] highCompBThreshold_ff,
    output reg [6:0] highGainA_ff,
    output reg [6:0] highGainB_ff,
    // Filtered comparator levels
    output wire [2:0] lowCompOut,
    output wire [2:0] highCompOut
);

`include "current_monitor_consts.vh"

// ----------------------------------------
// Register map
// ----------------------------------------
// 0x34 low channel byte A
//   7:5 fast trip code, 4 filter bypass, 3 window select
//   2 low-side enable, 1:0 fixed zero
// 0x35 low channel byte B
//   7:6 A threshold, 5:4 B threshold, 3:2 A gain, 1:0 B gain
// 0x36 high channel byte A
//   as 0x34, bit 2 has no function and reads zero
// 0x37 high channel byte B
//   same layout as 0x35
// Gain codes 0 to 3 mean 100, 50, 25 and 10 V/V
// Threshold and gain pick the trip point in the analog section
// Bus writes and config loads share one mask per register,
// so a loaded value reads back exactly like a written one
// Offsets outside 0x34 to 0x37 store nothing and read zero

// ----------------------------------------
// Register storage
// ----------------------------------------
reg [7:0] cfgMem_ff [0:3];
reg [7:0] nxt_cfgMem [0:3];
reg [7:0] nxt_regRdData;

// Offsets 0x34..0x37 map to 4..7: bit 2 flags a hit, bits 1:0 give index 0..3
function [2:0] addrIndex;
    input [7:0] addr;
    begin
        case (addr)
            `LOW_CFG_A_ADDR: addrIndex = 3'h4;
            `LOW_CFG_B_ADDR: addrIndex = 3'h5;
            `HIGH_CFG_A_ADDR: addrIndex = 3'h6;
            `HIGH_CFG_B_ADDR: addrIndex = 3'h7;
            default: addrIndex = 3'h0;
        endcase
    end
endfunction

// Mask per register so fixed-zero and don't-care bits never store
function [7:0] regMask;
    input [1:0] idx;
    begin
        case (idx)
            2'h0: regMask = `LOW_A_MASK; // R2
            2'h2: regMask = `HIGH_A_MASK; // R3
            default: regMask = 8'hFF; // R4
        endcase
    end
endfunction

// Gain code to amplification in V/V
function [6:0] gainValue;
    input [1:0] code;
    begin
        case (code)
            2'h0: gainValue = `GAIN_CODE0;
            2'h1: gainValue = `GAIN_CODE1;
            2'h2: gainValue = `GAIN_CODE2;
            default: gainValue = `GAIN_CODE3;
        endcase
    end
endfunction

wire [2:0] wrSel = addrIndex(regAddr);
wire [2:0] ldSel = addrIndex(loadCfgAddr);
wire [2:0] rdSel = addrIndex(regAddr);

// One-hot hits per register, bit h high when a strobe selects entry h;
// unmapped offsets raise no hit, so they can never disturb storage
wire [3:0] wrHit;
wire [3:0] ldHit;
genvar h;
generate
    for (h = 0; h < 4; h = h + 1) begin : gHit
        assign wrHit[h] = regWrEn && wrSel[2] && (wrSel[1:0] == h);
        assign ldHit[h] = loadCfgEn && ldSel[2] && (ldSel[1:0] == h);
    end
endgenerate

// ----------------------------------------
// Write path
// ----------------------------------------
// Bus write wins over config load when both hit one register:
// the host's latest intent is what software expects to read back.
integer i;
integer j;
always @* begin
    for (i = 0; i < 4; i = i + 1) begin
        nxt_cfgMem[i] = cfgMem_ff[i];
        if (ldHit[i]) begin
            nxt_cfgMem[i] = loadCfgData & regMask(i[1:0]); // R11
        end
        if (wrHit[i]) begin
            nxt_cfgMem[i] = regWrData & regMask(i[1:0]); // R1
        end
    end
end

// Storage update; master and slave roles use the same port
// Own loop index so no variable is shared between processes
always @(posedge clk) begin
    for (j = 0; j < 4; j = j + 1) begin
        if (sys_rst) begin
            cfgMem_ff[j] <= (j[0]) ? `CFG_B_RESET : `CFG_A_RESET;
        end else begin
            cfgMem_ff[j] <= nxt_cfgMem[j]; // R11
        end
    end
end

// ----------------------------------------
// Read path
// ----------------------------------------
// Unmapped offsets read as zero
always @* begin
    nxt_regRdData = `RD_IDLE;
    if (rdSel[2]) begin
        nxt_regRdData = cfgMem_ff[rdSel[1:0]]; // R13
    end
end

// Read data lands one cycle after the strobe
always @(posedge clk) begin
    if (sys_rst) begin
        regRdData_ff <= `RD_IDLE;
        regRdValid_ff <= 1'b0;
    end else begin
        regRdValid_ff <= regRdEn;
        if (regRdEn) begin
            regRdData_ff <= nxt_regRdData;
        end
    end
end

// ----------------------------------------
// Decoded controls
// ----------------------------------------
// Next values for the analog side controls
reg [2:0] nxt_lowFastTripCode;
reg nxt_lowWindowSel;
reg nxt_lowLowSideEnable;
reg [1:0] nxt_lowCompAThreshold;
reg [1:0] nxt_lowCompBThreshold;
reg [6:0] nxt_lowGainA;
reg [6:0] nxt_lowGainB;
reg [2:0] nxt_highFastTripCode;
reg nxt_highWindowSel;
reg [1:0] nxt_highCompAThreshold;
reg [1:0] nxt_highCompBThreshold;
reg [6:0] nxt_highGainA;
reg [6:0] nxt_highGainB;

// Low channel fields; bypass goes raw to the filters
always @* begin
    nxt_lowFastTripCode = cfgMem_ff[0][`FAST_MSB:`FAST_LSB]; // R12
    nxt_lowWindowSel = cfgMem_ff[0][`WINDOW_BIT]; // R9
    nxt_lowLowSideEnable = cfgMem_ff[0][`LOWSIDE_BIT]; // R10
    nxt_lowCompAThreshold = cfgMem_ff[1][`ATH_MSB:`ATH_LSB]; // R5
    nxt_lowCompBThreshold = cfgMem_ff[1][`BTH_MSB:`BTH_LSB]; // R5
    nxt_lowGainA = gainValue(cfgMem_ff[1][`AGAIN_MSB:`AGAIN_LSB]); // R5
    nxt_lowGainB = gainValue(cfgMem_ff[1][`BGAIN_MSB:`BGAIN_LSB]); // R5
end

// High channel fields; bit 2 of byte A has no use here
always @* begin
    nxt_highFastTripCode = cfgMem_ff[2][`FAST_MSB:`FAST_LSB]; // R12
    nxt_highWindowSel = cfgMem_ff[2][`WINDOW_BIT]; // R9
    nxt_highCompAThreshold = cfgMem_ff[3][`ATH_MSB:`ATH_LSB]; // R6
    nxt_highCompBThreshold = cfgMem_ff[3][`BTH_MSB:`BTH_LSB]; // R6
    nxt_highGainA = gainValue(cfgMem_ff[3][`AGAIN_MSB:`AGAIN_LSB]); // R6
    nxt_highGainB = gainValue(cfgMem_ff[3][`BGAIN_MSB:`BGAIN_LSB]); // R6
end

// Registered decode keeps every output straight from a flip-flop;
// the analog side sees changes one cycle after the store.
always @(posedge clk) begin
    if (sys_rst) begin
        lowFastTripCode_ff <= 3'h0;
        lowWindowSel_ff <= 1'b0;
        lowLowSideEnable_ff <= 1'b0;
        lowCompAThreshold_ff <= 2'h0;
        lowCompBThreshold_ff <= 2'h0;
        lowGainA_ff <= `GAIN_CODE0;
        lowGainB_ff <= `GAIN_CODE0;
        highFastTripCode_ff <= 3'h0;
        highWindowSel_ff <= 1'b0;
        highCompAThreshold_ff <= 2'h0;
        highCompBThreshold_ff <= 2'h0;
        highGainA_ff <= `GAIN_CODE0;
        highGainB_ff <= `GAIN_CODE0;
    end else begin
        lowFastTripCode_ff <= nxt_lowFastTripCode;
        lowWindowSel_ff <= nxt_lowWindowSel;
        lowLowSideEnable_ff <= nxt_lowLowSideEnable;
        lowCompAThreshold_ff <= nxt_lowCompAThreshold;
        lowCompBThreshold_ff <= nxt_lowCompBThreshold;
        lowGainA_ff <= nxt_lowGainA;
        lowGainB_ff <= nxt_lowGainB;
        highFastTripCode_ff <= nxt_highFastTripCode;
        highWindowSel_ff <= nxt_highWindowSel;
        highCompAThreshold_ff <= nxt_highCompAThreshold;
        highCompBThreshold_ff <= nxt_highCompBThreshold;
        highGainA_ff <= nxt_highGainA;
        highGainB_ff <= nxt_highGainB;
    end
end

// ----------------------------------------
// Glitch filters, one per comparator output
// ----------------------------------------
wire lowBypass = cfgMem_ff[0][`BYPASS_BIT];
wire highBypass = cfgMem_ff[2][`BYPASS_BIT];

genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : gFilt
        wire outBit;
        // First three slots serve the low channel, the rest the high one
        wire bypassSel = (g < 3) ? lowBypass : highBypass;
        wire rawSel = (g < 3) ? lowCompRaw[g % 3] : highCompRaw[g % 3];
        glitch_filter uFilt ( // R7
            .clk(clk),
            .sys_rst(sys_rst),
            .bypass(bypassSel), // R8
            .compIn(rawSel),
            .compOut_ff(outBit)
        );
        if (g < 3) begin : gLow
            assign lowCompOut[g] = outBit;
        end else begin : gHigh
            assign highCompOut[g - 3] = outBit;
        end
    end
endgenerate

endmodule

/* File: tb/cmon_assertions.sv */
// Port checker for the current monitor register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module cmon_assertions (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register access
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire [7:0] regRdData_ff,
    input wire regRdValid_ff,
    // Low channel outputs
    input wire [2:0] lowCompRaw,
    input wire [2:0] lowCompOut,
    input wire lowLowSideEnable_ff,
    input wire [1:0] lowCompAThreshold_ff,
    input wire [6:0] lowGainA_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Gain code to V/V
    function automatic [6:0] gv(input [1:0] c);
        gv = (c == 2'h0) ? 7'h64 : (c == 2'h1) ? 7'h32 : (c == 2'h2) ? 7'h19 : 7'h0A;
    endfunction

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_read_valid_pulse: assert property (regRdEn |=> regRdValid_ff)
        else $error("read valid missing");
    a_valid_has_cause: assert property (regRdValid_ff |-> $past(regRdEn))
        else $error("read valid without read");
    a_low_zero_bits: assert property (regRdEn && regAddr == 8'h34 |=> regRdData_ff[1:0] == 2'h0)
        else $error("low byte A fixed bits not zero");
    a_high_zero_bits: assert property (regRdEn && regAddr == 8'h36 |=> regRdData_ff[2:0] == 3'h0)
        else $error("high byte A low bits not zero");
    a_unmapped_read_zero: assert property (regRdEn && (regAddr < 8'h34 || regAddr > 8'h37)
        |=> regRdData_ff == 8'h00)
        else $error("unmapped read not zero");
    a_threshold_decode: assert property (regWrEn && regAddr == 8'h35 ##1 !(regWrEn && regAddr == 8'h35)
        |=> lowCompAThreshold_ff == $past(regWrData[7:6], 2))
        else $error("A threshold not decoded");
    a_gain_decode: assert property (regWrEn && regAddr == 8'h35 ##1 !(regWrEn && regAddr == 8'h35)
        |=> lowGainA_ff == gv($past(regWrData[3:2], 2)))
        else $error("A gain not decoded");
    a_lowside_follow: assert property (regWrEn && regAddr == 8'h34 ##1 !(regWrEn && regAddr == 8'h34)
        |=> lowLowSideEnable_ff == $past(regWrData[2], 2))
        else $error("low-side enable not decoded");
    // Filtered or bypassed, a change must follow the raw level
    a_filter_cause: assert property ($changed(lowCompOut[1])
        |-> lowCompOut[1] == $past(lowCompRaw[1]) || lowCompOut[1] == $past(lowCompRaw[1], 2))
        else $error("comparator output changed without cause");
endmodule

bind current_monitor_config_regs cmon_assertions chk (.clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData_ff(regRdData_ff),
    .regRdValid_ff(regRdValid_ff), .lowCompRaw(lowCompRaw), .lowCompOut(lowCompOut),
    .lowLowSideEnable_ff(lowLowSideEnable_ff), .lowCompAThreshold_ff(lowCompAThreshold_ff),
    .lowGainA_ff(lowGainA_ff));

/* File: tb/cmon_host_model.sv */
// Host side model: serial engine byte writes, reads and config loads.
// Assumes the caller waits for reset release before the first access.
`timescale 1ns/10ps

module cmon_host_model (
    // Clock
    input wire clk,
    // Read answer
    input wire [7:0] regRdData_ff,
    input wire regRdValid_ff,
    // Requests
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic loadCfgEn,
    output logic [7:0] loadCfgAddr,
    output logic [7:0] loadCfgData
);
    initial begin
        {regWrEn, regRdEn, loadCfgEn} = 3'h0;
        {regAddr, regWrData, loadCfgAddr, loadCfgData} = 32'h0;
    end
    // Byte write; data inverted after release so stale data never looks valid
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask
    // Config load write
    task ld(input [7:0] a, input [7:0] d);
        @(posedge clk);
        loadCfgEn <= 1'b1;
        loadCfgAddr <= a;
        loadCfgData <= d;
        @(posedge clk);
        loadCfgEn <= 1'b0;
        loadCfgData <= ~d;
    endtask
    // Read; data taken at the edge where valid is seen, inverted if valid is missing
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(posedge clk);
        d = regRdValid_ff ? regRdData_ff : ~regRdData_ff;
    endtask
endmodule

/* File: tb/current_monitor_config_regs_bench.sv */
// Self-checking bench for the current monitor register bank.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/10ps

module current_monitor_config_regs_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] lowCompRaw = 3'h0;
    logic [2:0] highCompRaw = 3'h0;
    wire regWrEn, regRdEn, loadCfgEn, rdValid, lWin, lSide, hWin;
    wire [7:0] regAddr, regWrData, loadCfgAddr, loadCfgData, rdData;
    wire [2:0] lFast, hFast, lOut, hOut;
    wire [1:0] lAth, lBth, hAth, hBth;
    wire [6:0] lGa, lGb, hGa, hGb;
    logic [7:0] q;
    logic [6:0] gains [4] = '{7'h64, 7'h32, 7'h19, 7'h0A};
    int fails = 0;
    int compares = 0;

    always #25 clk = ~clk;

    current_monitor_config_regs dut (.clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData_ff(rdData), .regRdValid_ff(rdValid),
        .loadCfgEn(loadCfgEn), .loadCfgAddr(loadCfgAddr), .loadCfgData(loadCfgData),
        .lowCompRaw(lowCompRaw), .highCompRaw(highCompRaw), .lowFastTripCode_ff(lFast),
        .lowWindowSel_ff(lWin), .lowLowSideEnable_ff(lSide), .lowCompAThreshold_ff(lAth),
        .lowCompBThreshold_ff(lBth), .lowGainA_ff(lGa), .lowGainB_ff(lGb), .highFastTripCode_ff(hFast),
        .highWindowSel_ff(hWin), .highCompAThreshold_ff(hAth), .highCompBThreshold_ff(hBth),
        .highGainA_ff(hGa), .highGainB_ff(hGb), .lowCompOut(lOut), .highCompOut(hOut));

    cmon_host_model host (.clk(clk), .regRdData_ff(rdData), .regRdValid_ff(rdValid), .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .loadCfgEn(loadCfgEn), .loadCfgAddr(loadCfgAddr),
        .loadCfgData(loadCfgData));

    // ----------------------------------------
    // Compare and finish
    // ----------------------------------------
    task ck(input string n, input [7:0] e, input [7:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Decoded outputs land two edges after the strobe
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Bound generous enough for every test below
    initial begin
        #(3000 * 50);
        fails++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 8'h34; a < 8'h38; a++) begin
            host.rd(a[7:0], q);
            ck("reset value", 8'h00, q);
        end
        ck("reset gain", 8'h64, {1'b0, hGb});
        $display("reset values done");
        host.wr(8'h34, 8'hFF);
        host.rd(8'h34, q);
        ck("low byte A", 8'hFC, q);
        ck("low window", 8'h01, {7'h0, lWin});
        ck("low side", 8'h01, {7'h0, lSide});
        host.wr(8'h36, 8'hFF);
        host.wr(8'h38, 8'hAA);
        host.rd(8'h36, q);
        ck("high byte A", 8'hF8, q);
        ck("high window", 8'h01, {7'h0, hWin});
        host.rd(8'h38, q);
        ck("unmapped", 8'h00, q);
        $display("byte A layout done");
        // Every threshold and gain code on both channels
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h35, {4{i[1:0]}});
            host.wr(8'h37, {4{i[1:0]}});
            settle;
            ck("low A gain", {1'b0, gains[i]}, {1'b0, lGa});
            ck("low B gain", {1'b0, gains[i]}, {1'b0, lGb});
            ck("high A gain", {1'b0, gains[i]}, {1'b0, hGa});
            ck("high B gain", {1'b0, gains[i]}, {1'b0, hGb});
            ck("thresholds", {i[1:0], i[1:0], i[1:0], i[1:0]}, {lAth, lBth, hAth, hBth});
        end
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h34, {i[2:0], 5'h00});
            host.wr(8'h36, {i[2:0], 5'h00});
            settle;
            ck("fast codes, window off", {2'h0, i[2:0], i[2:0]}, {lWin, hWin, lFast, hFast});
        end
        host.ld(8'h37, 8'hC0);
        host.rd(8'h37, q);
        ck("load write", 8'hC0, q);
        $display("decode done");
        // Short pulse rejected, long level passes, then bypass
        @(posedge clk);
        lowCompRaw <= 3'h2;
        repeat (2) @(posedge clk);
        lowCompRaw <= 3'h0;
        repeat (8) @(posedge clk);
        #1 ck("glitch kept out", 8'h00, {5'h0, lOut});
        @(posedge clk);
        lowCompRaw <= 3'h7;
        highCompRaw <= 3'h5;
        repeat (7) @(posedge clk);
        #1 ck("filtered level", 8'h07, {5'h0, lOut});
        ck("high filtered level", 8'h05, {5'h0, hOut});
        host.wr(8'h34, 8'h10);
        settle;
        @(posedge clk);
        lowCompRaw <= 3'h0;
        @(posedge clk);
        #1 ck("bypassed level", 8'h00, {5'h0, lOut});
        $display("filter done");
        stop_test;
    end
endmodule
